// *** verilog/kjc_pkg.sv ***
`default_nettype none
package kjc_pkg;
  // register map, byte-wide registers addressed by the command byte
  localparam logic [7:0] ADDR_STATUS1 = 8'h00;
  localparam logic [7:0] ADDR_SECOND_STATUS_REGISTER = 8'h01;
  localparam logic [7:0] ADDR_STATUS3 = 8'h02;
  localparam logic [7:0] ADDR_MASK1 = 8'h04;
  localparam logic [7:0] ADDR_MASK2 = 8'h05;
  localparam logic [7:0] ADDR_VOL_LEFT = 8'h07;
  localparam logic [7:0] ADDR_VOL_RIGHT = 8'h08;
  localparam logic [7:0] ADDR_KEY_DIV_HIGH = 8'h12;
  localparam logic [7:0] ADDR_KEY_DIV_LOW = 8'h13;
  localparam logic [7:0] ADDR_KEY_DIV_ADC = 8'h14;
  localparam logic [7:0] ADDR_DEBOUNCE = 8'h15;
  localparam logic [7:0] ADDR_DELAY = 8'h16;
  localparam logic [7:0] ADDR_KEYSCAN_RESULT = 8'h17;
  localparam logic [7:0] ADDR_ENABLE1 = 8'h1d;
  localparam logic [7:0] ADDR_ENABLE2 = 8'h1e;
  localparam logic [7:0] ADDR_AUTO_CFG = 8'h1f;

  // field positions
  localparam int KEY_FLAG_BIT = 2;      // second_status_register
  localparam int JACK_FLAG_BIT = 7;     // status1, jack detection finished
  localparam int PRESS_BIT = 7;         // keyscan_result
  localparam int TRACK_BIT = 7;         // left volume register

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // volume code 0 is -60 dB, 1 dB per step, top code is +6 dB
  localparam logic [6:0] VOL_MAX = 7'h42;

  // auto configuration enables per detected load kind {enable2, enable1}
  localparam logic [15:0] AUTO_EN_NONE = 16'h0000;
  localparam logic [15:0] AUTO_EN_HEADPHONE = 16'h0683;
  localparam logic [15:0] AUTO_EN_HEADSET = 16'h1e83;
  localparam logic [15:0] AUTO_EN_LINE = 16'h0603;

  // keyscan timing: debounce unit 1 ms, delay unit 4 ms
  localparam logic [10:0] DELAY_MULT = 11'h004;
  localparam logic [10:0] ONE_STEP = 11'h001;

  typedef enum logic [1:0] {
    KJC_LOAD_NONE = 2'b00,
    KJC_LOAD_HEADPHONE = 2'b01,
    KJC_LOAD_HEADSET = 2'b10,
    KJC_LOAD_LINE = 2'b11
  } kjc_load_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } kjc_wr_t;
endpackage
`default_nettype wire

// *** verilog/kjc_i2c_slave.sv ***
`default_nettype none
module kjc_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h40
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [7:0] rd_data_i,
  output logic sda_oe_o,
  output logic [7:0] cmd_o,
  output logic wr_valid_o,
  output kjc_pkg::kjc_wr_t wr_o,
  output logic rd_strobe_o
);
  typedef enum logic [3:0] {
    KJC_I_IDLE = 4'b0000, KJC_I_ADDR = 4'b0001, KJC_I_ACK_ADDR = 4'b0010,
    KJC_I_CMD = 4'b0011, KJC_I_ACK_CMD = 4'b0100, KJC_I_WDATA = 4'b0101,
    KJC_I_ACK_WDATA = 4'b0110, KJC_I_RDATA = 4'b0111, KJC_I_RACK = 4'b1000
  } kjc_i2c_st_t;

  kjc_i2c_st_t st_reg, st_next;
  logic scl_reg, sda_reg, rw_reg, rw_next, oe_reg, oe_next, wr_reg, wr_next, rd_reg, rd_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next, cmd_reg, cmd_next;
  logic rise, fall, start_c, stop_c;

  assign rise = scl_i & ~scl_reg;
  assign fall = ~scl_i & scl_reg;
  assign start_c = scl_i & scl_reg & sda_reg & ~sda_i;
  assign stop_c = scl_i & scl_reg & ~sda_reg & sda_i;

  // byte engine, the command byte becomes the register address
  always_comb
  begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    cmd_next = cmd_reg;
    rw_next = rw_reg;
    oe_next = oe_reg;
    wr_next = 1'b0;
    rd_next = 1'b0;
    if (start_c)
    begin
      st_next = KJC_I_ADDR; // a repeated start also lands here
      cnt_next = 4'h0;
      oe_next = 1'b0;
    end
    else if (stop_c)
    begin
      st_next = KJC_I_IDLE;
      oe_next = 1'b0;
    end
    else if (rise && (st_reg == KJC_I_ADDR || st_reg == KJC_I_CMD || st_reg == KJC_I_WDATA))
    begin
      sh_next = {sh_reg[6:0], sda_i};
      cnt_next = cnt_reg + 4'h1;
    end
    else if (fall)
    begin
      case (st_reg)
        KJC_I_ADDR: if (cnt_reg == 4'h8)
        begin
          rw_next = sh_reg[0];
          oe_next = (sh_reg[7:1] == DEV_ADDR);
          st_next = (sh_reg[7:1] == DEV_ADDR) ? KJC_I_ACK_ADDR : KJC_I_IDLE;
        end
        KJC_I_ACK_ADDR:
        begin
          cnt_next = 4'h0;
          oe_next = 1'b0;
          st_next = KJC_I_CMD;
          if (rw_reg)
          begin
            oe_next = ~rd_data_i[7]; // read answers the register last named
            sh_next = {rd_data_i[6:0], 1'b0};
            cnt_next = 4'h1;
            rd_next = 1'b1;
            st_next = KJC_I_RDATA;
          end
        end
        KJC_I_CMD: if (cnt_reg == 4'h8)
        begin
          cmd_next = sh_reg;
          oe_next = 1'b1;
          st_next = KJC_I_ACK_CMD;
        end
        KJC_I_ACK_CMD, KJC_I_ACK_WDATA:
        begin
          oe_next = 1'b0;
          cnt_next = 4'h0;
          st_next = (st_reg == KJC_I_ACK_CMD) ? KJC_I_WDATA : KJC_I_IDLE;
        end
        KJC_I_WDATA: if (cnt_reg == 4'h8)
        begin
          wr_next = 1'b1;
          oe_next = 1'b1;
          st_next = KJC_I_ACK_WDATA;
        end
        KJC_I_RDATA:
        begin
          oe_next = (cnt_reg == 4'h8) ? 1'b0 : ~sh_reg[7];
          sh_next = {sh_reg[6:0], 1'b0};
          cnt_next = cnt_reg + 4'h1;
          st_next = (cnt_reg == 4'h8) ? KJC_I_RACK : KJC_I_RDATA;
        end
        KJC_I_RACK: st_next = KJC_I_IDLE; // single byte only
        default: st_next = KJC_I_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_reg <= KJC_I_IDLE;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      cmd_reg <= 8'h00;
      rw_reg <= 1'b0;
      oe_reg <= 1'b0;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      scl_reg <= scl_i;
      sda_reg <= sda_i;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      cmd_reg <= cmd_next;
      rw_reg <= rw_next;
      oe_reg <= oe_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end

  assign sda_oe_o = oe_reg;
  assign cmd_o = cmd_reg;
  assign wr_valid_o = wr_reg;
  assign wr_o = '{addr: cmd_reg, data: sh_reg};
  assign rd_strobe_o = rd_reg;
endmodule // kjc_i2c_slave
`default_nettype wire

// *** verilog/kjc_regs.sv ***
// Contract
// - debounce code n gives n+1 milliseconds
// - delay code n gives 4(n+1) milliseconds
// - keyscan result readable at address 0x17
// - result bit 7 high press, low release
// - key flag bit 2 of second status
// - auto mode enables blocks by load type
// - no block enabled before jack detection done
// - volume spans -60 dB to +6 dB
// - tracking makes right volume follow left
// - command byte is the register address
// - timing clock divides by 16-bit pair 0x12/0x13
// - converter clock divides by 8-bit 0x14
// - flag drives interrupt only when enabled
`default_nettype none
module kjc_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h40
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic key_active_i,
  input wire logic [6:0] key_code_i,
  input wire logic jack_done_i,
  input wire logic [1:0] jack_load_i,
  output logic [15:0] block_en_o,
  output logic [6:0] vol_left_o,
  output logic [6:0] vol_right_o,
  output logic key_tick_o,
  output logic adc_clk_en_o,
  output logic irq_o,
  output logic irq_oe_o
);
  typedef enum logic [1:0] {
    KJC_KS_IDLE = 2'b00,
    KJC_KS_DEBOUNCE = 2'b01,
    KJC_KS_DELAY = 2'b10
  } kjc_ks_t;

  logic [7:0] cmd;
  logic wr_valid, rd_strobe, sda_oe_i2c;
  kjc_pkg::kjc_wr_t wr;
  logic [7:0] rd_data;

  logic [7:0] st1_reg, st1_next, st2_reg, st2_next, mask1_reg, mask1_next, mask2_reg, mask2_next;
  logic [7:0] vol_l_reg, vol_l_next, vol_r_reg, vol_r_next;
  logic [7:0] div_hi_reg, div_hi_next, div_lo_reg, div_lo_next, div_adc_reg, div_adc_next;
  logic [7:0] deb_reg, deb_next, dly_reg, dly_next, res_reg, res_next;
  logic [7:0] en1_reg, en1_next, en2_reg, en2_next, auto_reg, auto_next;
  logic [15:0] kdiv_cnt_reg, kdiv_cnt_next;
  logic [7:0] adiv_cnt_reg, adiv_cnt_next;
  logic half_reg, half_next, ms_tick_reg, ms_tick_next, adc_en_reg, adc_en_next;
  kjc_ks_t ks_reg, ks_next;
  logic lvl_reg, lvl_next, done_q_reg, done_q_next, key_evt;
  logic [10:0] ms_cnt_reg, ms_cnt_next;
  logic [15:0] en_reg, en_next, auto_en;
  logic [6:0] vl_reg, vl_next, vr_reg, vr_next;
  logic irq_reg, irq_next;

  kjc_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_i2c (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .rd_data_i(rd_data),
    .sda_oe_o(sda_oe_i2c),
    .cmd_o(cmd),
    .wr_valid_o(wr_valid),
    .wr_o(wr),
    .rd_strobe_o(rd_strobe)
  );

  // read mux, unmapped addresses read as zero
  always_comb
  begin
    if (cmd == kjc_pkg::ADDR_STATUS1) rd_data = st1_reg;
    else if (cmd == kjc_pkg::ADDR_SECOND_STATUS_REGISTER) rd_data = st2_reg;
    else if (cmd == kjc_pkg::ADDR_STATUS3) rd_data = {6'h00, jack_load_i};
    else if (cmd == kjc_pkg::ADDR_MASK1) rd_data = mask1_reg;
    else if (cmd == kjc_pkg::ADDR_MASK2) rd_data = mask2_reg;
    else if (cmd == kjc_pkg::ADDR_VOL_LEFT) rd_data = vol_l_reg;
    else if (cmd == kjc_pkg::ADDR_VOL_RIGHT) rd_data = vol_r_reg;
    else if (cmd == kjc_pkg::ADDR_KEY_DIV_HIGH) rd_data = div_hi_reg;
    else if (cmd == kjc_pkg::ADDR_KEY_DIV_LOW) rd_data = div_lo_reg;
    else if (cmd == kjc_pkg::ADDR_KEY_DIV_ADC) rd_data = div_adc_reg;
    else if (cmd == kjc_pkg::ADDR_DEBOUNCE) rd_data = deb_reg;
    else if (cmd == kjc_pkg::ADDR_DELAY) rd_data = dly_reg;
    else if (cmd == kjc_pkg::ADDR_KEYSCAN_RESULT) rd_data = res_reg;
    else if (cmd == kjc_pkg::ADDR_ENABLE1) rd_data = en1_reg;
    else if (cmd == kjc_pkg::ADDR_ENABLE2) rd_data = en2_reg;
    else if (cmd == kjc_pkg::ADDR_AUTO_CFG) rd_data = auto_reg;
    else rd_data = 8'h00;
  end

  // writable registers; volume codes clamp so nothing exceeds +6 dB
  always_comb
  begin
    mask1_next = mask1_reg;
    mask2_next = mask2_reg;
    vol_l_next = vol_l_reg;
    vol_r_next = vol_r_reg;
    div_hi_next = div_hi_reg;
    div_lo_next = div_lo_reg;
    div_adc_next = div_adc_reg;
    deb_next = deb_reg;
    dly_next = dly_reg;
    en1_next = en1_reg;
    en2_next = en2_reg;
    auto_next = auto_reg;
    if (wr_valid)
    begin
      if (wr.addr == kjc_pkg::ADDR_MASK1) mask1_next = wr.data;
      else if (wr.addr == kjc_pkg::ADDR_MASK2) mask2_next = wr.data;
      else if (wr.addr == kjc_pkg::ADDR_VOL_LEFT)
        vol_l_next = {wr.data[7], (wr.data[6:0] > kjc_pkg::VOL_MAX) ? kjc_pkg::VOL_MAX : wr.data[6:0]};
      else if (wr.addr == kjc_pkg::ADDR_VOL_RIGHT)
        vol_r_next = {1'b0, (wr.data[6:0] > kjc_pkg::VOL_MAX) ? kjc_pkg::VOL_MAX : wr.data[6:0]};
      else if (wr.addr == kjc_pkg::ADDR_KEY_DIV_HIGH) div_hi_next = wr.data;
      else if (wr.addr == kjc_pkg::ADDR_KEY_DIV_LOW) div_lo_next = wr.data;
      else if (wr.addr == kjc_pkg::ADDR_KEY_DIV_ADC) div_adc_next = wr.data;
      else if (wr.addr == kjc_pkg::ADDR_DEBOUNCE) deb_next = wr.data;
      else if (wr.addr == kjc_pkg::ADDR_DELAY) dly_next = wr.data;
      else if (wr.addr == kjc_pkg::ADDR_ENABLE1) en1_next = wr.data;
      else if (wr.addr == kjc_pkg::ADDR_ENABLE2) en2_next = wr.data;
      else if (wr.addr == kjc_pkg::ADDR_AUTO_CFG) auto_next = wr.data;
    end
  end

  // clock dividers; a divisor of zero stops the divider rather than run wild
  always_comb
  begin
    kdiv_cnt_next = kdiv_cnt_reg;
    half_next = half_reg;
    ms_tick_next = 1'b0;
    adiv_cnt_next = adiv_cnt_reg;
    adc_en_next = 1'b0;
    if ({div_hi_reg, div_lo_reg} != kjc_pkg::RST_WORD)
    begin
      kdiv_cnt_next = kdiv_cnt_reg + 16'h0001;
      if (kdiv_cnt_reg >= {div_hi_reg, div_lo_reg} - 16'h0001)
      begin
        kdiv_cnt_next = kjc_pkg::RST_WORD;
        half_next = ~half_reg;
        ms_tick_next = half_reg; // two half periods make one millisecond
      end
    end
    if (div_adc_reg != kjc_pkg::RST_BYTE)
    begin
      adiv_cnt_next = adiv_cnt_reg + 8'h01;
      if (adiv_cnt_reg >= div_adc_reg - 8'h01)
      begin
        adiv_cnt_next = kjc_pkg::RST_BYTE;
        adc_en_next = 1'b1;
      end
    end
  end

  // keyscan sequence: debounce both edges, delay only before a press is captured
  always_comb
  begin
    ks_next = ks_reg;
    lvl_next = lvl_reg;
    ms_cnt_next = ms_cnt_reg;
    res_next = res_reg;
    key_evt = 1'b0;
    case (ks_reg)
      KJC_KS_IDLE:
        if (key_active_i != lvl_reg)
        begin
          ks_next = KJC_KS_DEBOUNCE;
          ms_cnt_next = 11'h000;
        end
      KJC_KS_DEBOUNCE:
        if (key_active_i == lvl_reg)
          ks_next = KJC_KS_IDLE; // bounced back, nothing reported
        else if (ms_tick_reg)
        begin
          ms_cnt_next = ms_cnt_reg + kjc_pkg::ONE_STEP;
          if (ms_cnt_next == {3'h0, deb_reg} + kjc_pkg::ONE_STEP)
          begin
            lvl_next = key_active_i;
            ms_cnt_next = 11'h000;
            ks_next = key_active_i ? KJC_KS_DELAY : KJC_KS_IDLE;
            if (!key_active_i)
            begin
              res_next = {1'b0, res_reg[6:0]};
              key_evt = 1'b1;
            end
          end
        end
      KJC_KS_DELAY:
        if (ms_tick_reg)
        begin
          ms_cnt_next = ms_cnt_reg + kjc_pkg::ONE_STEP;
          if (ms_cnt_next == ({3'h0, dly_reg} + kjc_pkg::ONE_STEP) * kjc_pkg::DELAY_MULT)
          begin
            res_next = {1'b1, key_code_i};
            key_evt = 1'b1;
            ks_next = KJC_KS_IDLE;
          end
        end
      default: ks_next = KJC_KS_IDLE;
    endcase
  end

  // sticky flags, cleared by reading; a new event beats the clear
  always_comb
  begin
    done_q_next = jack_done_i;
    st1_next = st1_reg;
    st2_next = st2_reg;
    if (rd_strobe && cmd == kjc_pkg::ADDR_STATUS1) st1_next = 8'h00;
    if (rd_strobe && cmd == kjc_pkg::ADDR_SECOND_STATUS_REGISTER) st2_next = 8'h00;
    if (jack_done_i && !done_q_reg) st1_next[kjc_pkg::JACK_FLAG_BIT] = 1'b1;
    if (key_evt) st2_next[kjc_pkg::KEY_FLAG_BIT] = 1'b1;
    irq_next = |(st1_reg & mask1_reg) | |(st2_reg & mask2_reg);
  end

  // block enables and effective volumes
  always_comb
  begin
    case (kjc_pkg::kjc_load_t'(jack_load_i))
      kjc_pkg::KJC_LOAD_HEADPHONE: auto_en = kjc_pkg::AUTO_EN_HEADPHONE;
      kjc_pkg::KJC_LOAD_HEADSET: auto_en = kjc_pkg::AUTO_EN_HEADSET;
      kjc_pkg::KJC_LOAD_LINE: auto_en = kjc_pkg::AUTO_EN_LINE;
      default: auto_en = kjc_pkg::AUTO_EN_NONE;
    endcase
    if (!jack_done_i) en_next = kjc_pkg::RST_WORD;
    else if (auto_reg != kjc_pkg::RST_BYTE) en_next = auto_en;
    else en_next = {en2_reg, en1_reg};
    vl_next = vol_l_reg[6:0];
    vr_next = vol_l_reg[kjc_pkg::TRACK_BIT] ? vol_l_reg[6:0] : vol_r_reg[6:0];
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st1_reg <= kjc_pkg::RST_BYTE;
      st2_reg <= kjc_pkg::RST_BYTE;
      mask1_reg <= kjc_pkg::RST_BYTE;
      mask2_reg <= kjc_pkg::RST_BYTE;
      vol_l_reg <= kjc_pkg::RST_BYTE;
      vol_r_reg <= kjc_pkg::RST_BYTE;
      div_hi_reg <= kjc_pkg::RST_BYTE;
      div_lo_reg <= kjc_pkg::RST_BYTE;
      div_adc_reg <= kjc_pkg::RST_BYTE;
      deb_reg <= kjc_pkg::RST_BYTE;
      dly_reg <= kjc_pkg::RST_BYTE;
      res_reg <= kjc_pkg::RST_BYTE;
      en1_reg <= kjc_pkg::RST_BYTE;
      en2_reg <= kjc_pkg::RST_BYTE;
      auto_reg <= kjc_pkg::RST_BYTE;
      kdiv_cnt_reg <= kjc_pkg::RST_WORD;
      adiv_cnt_reg <= kjc_pkg::RST_BYTE;
      half_reg <= 1'b0;
      ms_tick_reg <= 1'b0;
      adc_en_reg <= 1'b0;
      ks_reg <= KJC_KS_IDLE;
      lvl_reg <= 1'b0;
      ms_cnt_reg <= 11'h000;
      done_q_reg <= 1'b0;
      en_reg <= kjc_pkg::RST_WORD;
      vl_reg <= 7'h00;
      vr_reg <= 7'h00;
      irq_reg <= 1'b0;
    end
    else
    begin
      st1_reg <= st1_next;
      st2_reg <= st2_next;
      mask1_reg <= mask1_next;
      mask2_reg <= mask2_next;
      vol_l_reg <= vol_l_next;
      vol_r_reg <= vol_r_next;
      div_hi_reg <= div_hi_next;
      div_lo_reg <= div_lo_next;
      div_adc_reg <= div_adc_next;
      deb_reg <= deb_next;
      dly_reg <= dly_next;
      res_reg <= res_next;
      en1_reg <= en1_next;
      en2_reg <= en2_next;
      auto_reg <= auto_next;
      kdiv_cnt_reg <= kdiv_cnt_next;
      adiv_cnt_reg <= adiv_cnt_next;
      half_reg <= half_next;
      ms_tick_reg <= ms_tick_next;
      adc_en_reg <= adc_en_next;
      ks_reg <= ks_next;
      lvl_reg <= lvl_next;
      ms_cnt_reg <= ms_cnt_next;
      done_q_reg <= done_q_next;
      en_reg <= en_next;
      vl_reg <= vl_next;
      vr_reg <= vr_next;
      irq_reg <= irq_next;
    end
  end

  // open-drain pins: the driven level is always low
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe_i2c;
  assign irq_o = 1'b0;
  assign irq_oe_o = irq_reg;
  assign block_en_o = en_reg;
  assign vol_left_o = vl_reg;
  assign vol_right_o = vr_reg;
  assign key_tick_o = ms_tick_reg;
  assign adc_clk_en_o = adc_en_reg;
endmodule // kjc_regs
`default_nettype wire

// *** dv/kjc_regs_chk.sv ***
`default_nettype none
module kjc_regs_chk (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic jack_done_i,
  input wire logic [15:0] block_en_o,
  input wire logic [6:0] vol_left_o,
  input wire logic [6:0] vol_right_o,
  input wire logic key_tick_o,
  input wire logic irq_o,
  input wire logic irq_oe_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // enables stay dark until jack detection is over
  a_block_gate: assert property (!jack_done_i |=> block_en_o == 16'h0000)
    else $error("block enable without finished jack detection");
  a_block_cause: assert property ($changed(block_en_o) |-> $past(jack_done_i) || block_en_o == 16'h0000)
    else $error("block enable changed while detection pending");
  // volume codes never leave the -60 dB .. +6 dB span
  a_left_span: assert property (vol_left_o <= kjc_pkg::VOL_MAX)
    else $error("left volume beyond top code");
  a_right_span: assert property (vol_right_o <= kjc_pkg::VOL_MAX)
    else $error("right volume beyond top code");
  // device may only grab the data line while the bus clock is low
  a_ack_low_clk: assert property ($rose(sda_oe_o) |-> !scl_i && !$past(scl_i))
    else $error("data line pulled while clock high");
  a_sda_steady: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
    else $error("data line moved during clock high");
  a_tick_single: assert property (key_tick_o |=> !key_tick_o)
    else $error("millisecond tick longer than one cycle");
  // open-drain pins only ever drive low
  a_open_drain: assert property (sda_o == 1'b0 && irq_o == 1'b0)
    else $error("open-drain pin driven high");
  c_blocks_on: cover property (block_en_o != 16'h0000);
  c_irq_on: cover property ($rose(irq_oe_o));
  c_acked: cover property ($rose(sda_oe_o));
endmodule // kjc_regs_chk
bind kjc_regs kjc_regs_chk u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .jack_done_i(jack_done_i), .block_en_o(block_en_o), .vol_left_o(vol_left_o),
  .vol_right_o(vol_right_o), .key_tick_o(key_tick_o), .irq_o(irq_o), .irq_oe_o(irq_oe_o));
`default_nettype wire

// *** dv/kjc_host_model.sv ***
`default_nettype none
module kjc_host_model (
  input wire logic clock_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [6:0] dev = 7'h40;
  // bus idles released, both lines high
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // changes land 1 ns after an edge so the device sees settled levels
  task automatic tk(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic put(input logic b);
    sda_o = b;
    tk(2);
    scl_o = 1'b1;
    tk(4);
    scl_o = 1'b0;
    tk(2);
  endtask
  // released line reads the pull-up unless the device holds it low
  task automatic get(output logic b);
    sda_o = 1'b1;
    tk(2);
    scl_o = 1'b1;
    tk(2);
    b = sda_i;
    tk(2);
    scl_o = 1'b0;
    tk(2);
  endtask
  task automatic start;
    sda_o = 1'b1;
    tk(2);
    scl_o = 1'b1;
    tk(4);
    sda_o = 1'b0;
    tk(4);
    scl_o = 1'b0;
    tk(2);
  endtask
  task automatic stop;
    sda_o = 1'b0;
    tk(2);
    scl_o = 1'b1;
    tk(4);
    sda_o = 1'b1;
    tk(4);
  endtask
  task automatic send(input logic [7:0] x, inout logic ok);
    logic a;
    for (int i = 7; i >= 0; i--) put(x[i]);
    get(a);
    ok = ok & ~a;
  endtask
  // address, command, one data byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    ok = 1'b1;
    start;
    send({dev, 1'b0}, ok);
    send(a, ok);
    send(d, ok);
    stop;
  endtask
  // command, repeated start, one byte back, closed with no acknowledge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b1;
    start;
    send({dev, 1'b0}, ok);
    send(a, ok);
    start;
    send({dev, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(1'b1);
    stop;
  endtask
endmodule // kjc_host_model
`default_nettype wire

// *** dv/tb_keyscan_jack_config_regs.sv ***
`default_nettype none
module tb_keyscan_jack_config_regs;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic scl, host_sda, sda_o, sda_oe, key_tick, adc_en, irq, irq_oe;
  logic key_active = 1'b0;
  logic jack_done = 1'b0;
  logic [6:0] key_code = 7'h2a;
  logic [1:0] jack_load = 2'b00;
  logic [15:0] block_en;
  logic [6:0] vol_l, vol_r;
  logic [15:0] regs [5] = '{16'h1202, 16'h1300, 16'h1403, 16'h1501, 16'h1600};
  logic [15:0] auto_tab [4] = '{kjc_pkg::AUTO_EN_NONE, kjc_pkg::AUTO_EN_HEADPHONE, kjc_pkg::AUTO_EN_HEADSET,
    kjc_pkg::AUTO_EN_LINE};
  int miscompares = 0;
  int compares = 0;
  // wired-and bus with pull-up
  wire sda = host_sda & ~sda_oe;
  kjc_regs DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .key_active_i(key_active), .key_code_i(key_code), .jack_done_i(jack_done), .jack_load_i(jack_load),
    .block_en_o(block_en), .vol_left_o(vol_l), .vol_right_o(vol_r), .key_tick_o(key_tick),
    .adc_clk_en_o(adc_en), .irq_o(irq), .irq_oe_o(irq_oe));
  kjc_host_model u_host (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_o(host_sda));
  // 250 MHz reference
  initial
  begin
    forever #2 clock_i = ~clock_i;
  end
  task automatic cy(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wt(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    u_host.wr(a, d, ok);
    chk({15'h0000, ok}, 16'h0001);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic ok;
    logic [7:0] d;
    u_host.rd(a, d, ok);
    chk({7'h00, ok, d}, {8'h01, e});
  endtask
  // waits out n millisecond ticks, leaves 1 ns after the last; pulses are looked at settled, off the edge
  task automatic ticks(input int n);
    repeat (n) do cy(1); while (key_tick !== 1'b1);
  endtask
  // clocks from one pulse to the next
  task automatic gap(input logic adc, output int c);
    do cy(1); while ((adc ? adc_en : key_tick) !== 1'b1);
    c = 0;
    do
    begin
      cy(1);
      c++;
    end while ((adc ? adc_en : key_tick) !== 1'b1);
  endtask
  task automatic done(input string s);
    $display("test %s finished, %0d mismatches so far", s, miscompares);
  endtask
  task automatic conclude;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // a hang costs a mismatch; real run is near 80 us
  initial
  begin
    #300000;
    miscompares++;
    conclude;
  end
  initial
  begin
    int c;
    logic ok;
    cy(16);
    rst_n_i = 1'b1;
    cy(2);
    wt(8'h17, 8'hff);
    rc(8'h17, 8'h00);
    wt(8'h03, 8'h5a);
    rc(8'h03, 8'h00);
    foreach (regs[i]) wt(regs[i][15:8], regs[i][7:0]);
    foreach (regs[i]) rc(regs[i][15:8], regs[i][7:0]);
    u_host.dev = 7'h41;
    u_host.wr(8'h15, 8'hee, ok);
    chk({15'h0000, ok}, 16'h0000);
    u_host.dev = 7'h40;
    rc(8'h15, 8'h01);
    done("registers");
    // divider 0x0200 gives a tick each 1024 clocks, converter every 3
    gap(1'b0, c);
    chk(c[15:0], 16'h0400);
    gap(1'b1, c);
    chk(c[15:0], 16'h0003);
    done("dividers");
    // debounce 2 ms then delay 4 ms before the press is posted
    ticks(1);
    key_active = 1'b1;
    ticks(5);
    rc(8'h17, 8'h00);
    ticks(1);
    cy(2);
    rc(8'h17, 8'haa);
    rc(8'h01, 8'h04);
    rc(8'h01, 8'h00);
    key_active = 1'b0;
    ticks(1);
    rc(8'h17, 8'haa);
    ticks(1);
    cy(2);
    rc(8'h17, 8'h2a);
    rc(8'h01, 8'h04);
    done("keyscan");
    wt(8'h07, 8'h7f);
    wt(8'h08, 8'h10);
    cy(2);
    chk({2'b00, vol_l, vol_r}, {2'b00, 7'h42, 7'h10});
    wt(8'h07, 8'h85);
    wt(8'h08, 8'h20);
    cy(2);
    chk({2'b00, vol_l, vol_r}, {2'b00, 7'h05, 7'h05});
    done("volume");
    // manual enables held back until detection completes
    wt(8'h1d, 8'h5a);
    wt(8'h1e, 8'h3c);
    chk(block_en, 16'h0000);
    jack_done = 1'b1;
    cy(3);
    chk(block_en, 16'h3c5a);
    wt(8'h1f, 8'h01);
    foreach (auto_tab[i])
    begin
      jack_load = 2'(i);
      cy(3);
      chk(block_en, auto_tab[i]);
    end
    rc(8'h02, 8'h03);
    jack_done = 1'b0;
    cy(3);
    chk(block_en, 16'h0000);
    done("enables");
    // jack flag is pending; it reaches the pin only once unmasked
    chk({15'h0000, irq_oe}, 16'h0000);
    wt(8'h04, 8'h80);
    cy(2);
    chk({15'h0000, irq_oe}, 16'h0001);
    rc(8'h00, 8'h80);
    cy(2);
    chk({15'h0000, irq_oe}, 16'h0000);
    done("interrupt");
    conclude;
  end
endmodule // tb_keyscan_jack_config_regs
`default_nettype wire
